// ---- pso_pkg.sv ----
// pso_pkg: constants and types for the programmable driver-output selector.
// assumes one 40 MHz clock and register access from the serial host core.
package pso_pkg;

    // ----------------------------------------------------------------
    // sizes and offsets
    // ----------------------------------------------------------------
    localparam int          PSO_NUM_OUT   = 10;
    localparam int          PSO_NUM_CP    = 6;
    localparam logic [7:0]  PSO_CFG_OFFSET [PSO_NUM_OUT] = '{
        8'h07, 8'h0F, 8'h17, 8'h1F, 8'h27, 8'h2F, 8'h37, 8'h3F, 8'h47, 8'h4F
    };
    localparam logic [6:0]  PSO_CFG_RESET = 7'h00;
    localparam logic [7:0]  PSO_RD_UNMAPPED = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          PSO_SRC_MSB   = 6;
    localparam int          PSO_SRC_LSB   = 4;
    localparam int          PSO_PU_MSB    = 3;
    localparam int          PSO_PU_LSB    = 0;

    localparam logic [2:0]  PSO_SRC_OFF   = 3'h0;
    localparam logic [2:0]  PSO_SRC_SEQ   = 3'h1;
    localparam logic [2:0]  PSO_SRC_LOW   = 3'h2;
    localparam logic [2:0]  PSO_SRC_HIGH  = 3'h3;

    localparam logic [2:0]  PSO_PU_NONE   = 3'h0;
    localparam logic [2:0]  PSO_PU_CP     = 3'h1;
    localparam logic [2:0]  PSO_PU_RAIL1  = 3'h2;
    localparam logic [2:0]  PSO_PU_RAIL2  = 3'h3;
    localparam logic [2:0]  PSO_PU_RAIL3  = 3'h4;
    localparam logic [2:0]  PSO_PU_RAIL4  = 3'h5;
    localparam logic [2:0]  PSO_PU_UNDEF  = 3'h6;
    localparam logic [2:0]  PSO_PU_INT    = 3'h7;

    // ----------------------------------------------------------------
    // internal clock generator timing
    // ----------------------------------------------------------------
    localparam longint      PSO_REF_HZ    = 40000000;
    localparam longint      PSO_INTCLK_HZ = 100000;
    localparam int          PSO_HALF_CYC  = int'(PSO_REF_HZ / (2 * PSO_INTCLK_HZ));
    localparam logic [7:0]  PSO_HALF_LAST = 8'(PSO_HALF_CYC - 1);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PSO_RAIL_NONE  = 3'h0,
        PSO_RAIL_CP    = 3'h1,
        PSO_RAIL_ONE   = 3'h2,
        PSO_RAIL_TWO   = 3'h3,
        PSO_RAIL_THREE = 3'h4,
        PSO_RAIL_FOUR  = 3'h5,
        PSO_RAIL_INT   = 3'h7
    } pso_rail_type;

    typedef struct packed {
        logic         level;
        logic         enabled;
        logic         weakPulldown;
        pso_rail_type rail;
        logic         pushPull;
    } pso_drive_type;

endpackage : pso_pkg

// ---- pso_driver_decode.sv ----
// pso_driver_decode: turns one output's configuration into its drive state.
// assumes configuration, engine level and clock are synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module pso_driver_decode #(
    parameter bit HAS_CP = 1'b1
) (
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic [6:0]         cfgValue,
    input  wire logic               seqLevel,
    input  wire logic               intClk,
    output pso_pkg::pso_drive_type  driveState
);

    // ----------------------------------------------------------------
    // source and pull-up decode
    // ----------------------------------------------------------------
    wire logic [2:0] srcSel = cfgValue[pso_pkg::PSO_SRC_MSB:pso_pkg::PSO_SRC_LSB];
    wire logic [2:0] puRail = cfgValue[pso_pkg::PSO_PU_MSB:pso_pkg::PSO_PU_LSB + 1];
    wire logic       puPush = cfgValue[pso_pkg::PSO_PU_LSB];

    wire logic srcClock = srcSel[2];
    wire logic srcOff   = srcSel == pso_pkg::PSO_SRC_OFF;
    wire logic levelNext = srcClock ? intClk :
                           srcSel == pso_pkg::PSO_SRC_SEQ  ? seqLevel :
                           srcSel == pso_pkg::PSO_SRC_HIGH;

    // no pull-up for 000x, undefined 110x, and charge pump where absent
    wire logic railNone = puRail == pso_pkg::PSO_PU_NONE
                       || puRail == pso_pkg::PSO_PU_UNDEF
                       || (puRail == pso_pkg::PSO_PU_CP && !HAS_CP);
    wire logic railCp   = puRail == pso_pkg::PSO_PU_CP && HAS_CP;
    wire pso_pkg::pso_rail_type railNext = railNone ? pso_pkg::PSO_RAIL_NONE :
                                           railCp   ? pso_pkg::PSO_RAIL_CP :
                                           pso_pkg::pso_rail_type'(puRail);

    pso_pkg::pso_drive_type driveNext;
    assign driveNext.level        = srcOff ? 1'b0 : levelNext;
    assign driveNext.enabled      = !srcOff;
    assign driveNext.weakPulldown = srcOff;
    assign driveNext.rail         = railNext;
    assign driveNext.pushPull     = !railNone && !railCp && puPush;

    // ----------------------------------------------------------------
    // registered drive state
    // ----------------------------------------------------------------
    pso_pkg::pso_drive_type driveState_reg;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            driveState_reg <= '{level: 1'b0, enabled: 1'b0, weakPulldown: 1'b1,
                                rail: pso_pkg::PSO_RAIL_NONE, pushPull: 1'b0};
        end else begin
            driveState_reg <= driveNext;
        end
    end
    assign driveState = driveState_reg;

endmodule : pso_driver_decode
`default_nettype wire

// ---- pso_output_select.sv ----
// pso_output_select: ten configuration registers, clock generator, output drive.
// assumes the serial host core presents single-cycle register strobes.
`timescale 1ns/10ps
`default_nettype none
module pso_output_select (
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    input  wire logic [7:0]              regAddr,
    input  wire logic [7:0]              regWrData,
    input  wire logic                    regWrEn,
    input  wire logic                    regRdEn,
    output logic      [7:0]              regRdData,
    input  wire logic [9:0]              seqLevel,
    output logic                         intClkOut,
    output pso_pkg::pso_drive_type [9:0] driveState
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire logic [pso_pkg::PSO_NUM_OUT-1:0] addrHit;
    logic [6:0] cfgReg [pso_pkg::PSO_NUM_OUT];
    logic [6:0] rdSel;

    genvar gi;
    generate
        for (gi = 0; gi < pso_pkg::PSO_NUM_OUT; gi++) begin : g_hit
            assign addrHit[gi] = regAddr == pso_pkg::PSO_CFG_OFFSET[gi];
        end
    endgenerate

    always_comb begin
        rdSel = 7'h00;
        for (int i = 0; i < pso_pkg::PSO_NUM_OUT; i++) begin
            rdSel = rdSel | (addrHit[i] ? cfgReg[i] : 7'h00);
        end
    end

    wire logic       anyHit   = |addrHit;
    wire logic [7:0] rdNext   = anyHit ? {1'b0, rdSel} : pso_pkg::PSO_RD_UNMAPPED;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    generate
        for (gi = 0; gi < pso_pkg::PSO_NUM_OUT; gi++) begin : g_cfg
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    cfgReg[gi] <= pso_pkg::PSO_CFG_RESET;
                end else if (regWrEn && addrHit[gi]) begin
                    cfgReg[gi] <= regWrData[6:0];
                end
            end
        end
    endgenerate

    logic [7:0] regRdData_reg;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regRdData_reg <= pso_pkg::PSO_RD_UNMAPPED;
        end else if (regRdEn) begin
            regRdData_reg <= rdNext;
        end
    end
    assign regRdData = regRdData_reg;

    // ----------------------------------------------------------------
    // internal 100 kHz clock
    // ----------------------------------------------------------------
    logic [7:0] divCount_reg;
    logic       intClk_reg;
    wire logic  divLast  = divCount_reg == pso_pkg::PSO_HALF_LAST;
    wire logic [7:0] divCount_next = divLast ? 8'h00 : divCount_reg + 8'h01;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            divCount_reg <= 8'h00;
            intClk_reg   <= 1'b0;
        end else begin
            divCount_reg <= divCount_next;
            intClk_reg   <= intClk_reg ^ divLast;
        end
    end
    assign intClkOut = intClk_reg;

    // ----------------------------------------------------------------
    // per-output drive decode
    // ----------------------------------------------------------------
    generate
        for (gi = 0; gi < pso_pkg::PSO_NUM_OUT; gi++) begin : g_drv
            pso_driver_decode #(
                .HAS_CP (gi < pso_pkg::PSO_NUM_CP)
            ) u_decode (
                .ref_clk    (ref_clk),
                .sys_rst    (sys_rst),
                .cfgValue   (cfgReg[gi]),
                .seqLevel   (seqLevel[gi]),
                .intClk     (intClk_reg),
                .driveState (driveState[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_cfgWrite(int idx);
        regWrEn && regAddr == pso_pkg::PSO_CFG_OFFSET[idx];
    endsequence

    property p_wr_first;
        s_cfgWrite(0) |=> cfgReg[0] == $past(regWrData[6:0]);
    endproperty
    a_wr_first: assert property (p_wr_first) else $error("output one config not stored");

    property p_wr_last;
        s_cfgWrite(9) |=> cfgReg[9] == $past(regWrData[6:0]) && cfgReg[0] == $past(cfgReg[0]);
    endproperty
    a_wr_last: assert property (p_wr_last) else $error("output ten write wrong or leaked");

    property p_off;
        cfgReg[2][6:4] == 3'h0 |=> driveState[2].weakPulldown && !driveState[2].enabled
                                   && !driveState[2].level;
    endproperty
    a_off: assert property (p_off) else $error("disabled output not pulled down");

    property p_seq;
        cfgReg[2][6:4] == 3'h1 |=> driveState[2].level == $past(seqLevel[2])
                                   && driveState[2].enabled;
    endproperty
    a_seq: assert property (p_seq) else $error("output not following engine");

    property p_host;
        cfgReg[1][6:5] == 2'h1 |=> driveState[1].level == $past(cfgReg[1][4]);
    endproperty
    a_host: assert property (p_host) else $error("host level not driven");

    property p_clk;
        cfgReg[2][6] |=> driveState[2].level == $past(intClk_reg);
    endproperty
    a_clk: assert property (p_clk) else $error("clock source not routed");

    property p_clk_half;
        $changed(intClk_reg) |=> (!$changed(intClk_reg))[*8] ##192 $changed(intClk_reg);
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("internal clock half period wrong");

    property p_clk_edge;
        $changed(intClk_reg) |-> $past(divCount_reg) == pso_pkg::PSO_HALF_LAST;
    endproperty
    a_clk_edge: assert property (p_clk_edge) else $error("clock toggled off terminal count");

    property p_cp_low;
        cfgReg[5][3:1] == 3'h1 |=> driveState[5].rail == pso_pkg::PSO_RAIL_CP;
    endproperty
    a_cp_low: assert property (p_cp_low) else $error("charge pump missing on output six");

    property p_cp_high;
        cfgReg[6][3:1] == 3'h1 |=> driveState[6].rail == pso_pkg::PSO_RAIL_NONE;
    endproperty
    a_cp_high: assert property (p_cp_high) else $error("charge pump on output seven");

    property p_rail;
        cfgReg[7][3:1] == 3'h7 |=> driveState[7].rail == pso_pkg::PSO_RAIL_INT
                                   && driveState[7].pushPull == $past(cfgReg[7][0]);
    endproperty
    a_rail: assert property (p_rail) else $error("regulated rail select wrong");

    property p_undef;
        cfgReg[8][3:1] == 3'h6 |=> driveState[8].rail == pso_pkg::PSO_RAIL_NONE
                                   && !driveState[8].pushPull;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined pull-up not none");

    property p_bit7;
        regRdEn |=> !regRdData[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("unused bit reads high");

endmodule : pso_output_select
`default_nettype wire

// ---- pso_load_model.sv ----
// pso_load_model: supply enable inputs or gate loads on the driver outputs.
// assumes one drive state per output from pso_output_select.
`timescale 1ns/10ps
`default_nettype none
module pso_load_model (
    input  wire pso_pkg::pso_drive_type [9:0] driveState,
    output logic                        [9:0] pinHigh
);
    // no external resistor: an unpulled pin reads low
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            pinHigh[i] = driveState[i].enabled & driveState[i].level
                & (driveState[i].rail != pso_pkg::PSO_RAIL_NONE);
        end
    end
endmodule : pso_load_model
`default_nettype wire

// ---- programmable_output_select_tb.sv ----
// programmable_output_select_tb: self-checking bench for pso_output_select.
// assumes pso_pkg, the design and pso_load_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module programmable_output_select_tb;
    logic                         ref_clk   = 1'b0;
    logic                         sys_rst   = 1'b1;
    logic [7:0]                   regAddr   = 8'h00;
    logic [7:0]                   regWrData = 8'h00;
    logic                         regWrEn   = 1'b0;
    logic                         regRdEn   = 1'b0;
    logic [9:0]                   seqLevel  = 10'h2A5;
    logic [7:0]                   regRdData;
    logic                         intClkOut;
    pso_pkg::pso_drive_type [9:0] driveState;
    logic [9:0]                   pinHigh;
    int                           failures;
    int                           samples_checked;
    int                           cycleCount;

    pso_output_select u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .seqLevel(seqLevel), .intClkOut(intClkOut), .driveState(driveState));
    pso_load_model u_load (.driveState(driveState), .pinHigh(pinHigh));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 30000) begin
            failures = failures + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(string what, logic [7:0] expv, logic [7:0] got);
        samples_checked++;
        if (got !== expv) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge ref_clk);
        regWrEn   <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    function automatic logic [7:0] expDrive(int idx, logic [6:0] c, logic s);
        pso_pkg::pso_drive_type e;
        e = '0;
        e.enabled      = (c[6:4] != 3'h0);
        e.weakPulldown = (c[6:4] == 3'h0);
        e.level        = (c[6:4] == 3'h1) ? s : (c[6:4] == 3'h3);
        if (c[3:1] >= 3'h2 && c[3:1] != 3'h6) begin
            e.rail     = pso_pkg::pso_rail_type'(c[3:1]);
            e.pushPull = c[0];
        end else if (c[3:1] == 3'h1 && idx < 6) begin
            e.rail = pso_pkg::PSO_RAIL_CP;
        end
        return {1'b0, e};
    endfunction : expDrive

    // clock-sourced level is judged by duty count, not per cycle
    task automatic chkOut(int i, logic [6:0] c);
        logic [7:0] m;
        m = c[6] ? 8'h3F : 8'h7F;
        chk($sformatf("drive%0d", i), expDrive(i, c, seqLevel[i]) & m, {1'b0, driveState[i]} & m);
    endtask : chkOut

    task automatic t_reset();
        logic [7:0] d;
        for (int i = 0; i < 10; i++) begin
            chkOut(i, 7'h00);
            rd(8'(8'h07 + 8 * i), d);
            chk("cfgReset", 8'h00, d);
        end
        $display("test done: reset");
    endtask : t_reset

    task automatic t_regs();
        logic [7:0] d;
        for (int i = 0; i < 10; i++) begin
            wr(8'(8'h07 + 8 * i), 8'(8'h80 | (i * 11 + 1)));
        end
        wr(8'h08, 8'h55);
        rd(8'h08, d);
        chk("unmapped", 8'h00, d);
        for (int i = 0; i < 10; i++) begin
            rd(8'(8'h07 + 8 * i), d);
            chk("cfgRead", 8'(i * 11 + 1), d);
            chkOut(i, 7'(i * 11 + 1));
        end
        $display("test done: registers");
    endtask : t_regs

    task automatic t_source();
        int n;
        for (int s = 0; s < 8; s++) begin
            for (int v = 0; v < 2; v++) begin
                @(posedge ref_clk);
                seqLevel[2] <= v[0];
                wr(8'h17, {1'b0, 3'(s), 4'h5});
                settle();
                chkOut(2, {3'(s), 4'h5});
                if (s < 4) begin
                    chk("pin", {7'h00, s == 3 || (s == 1 && v == 1)}, {7'h00, pinHigh[2]});
                end else if (v == 0) begin
                    n = 0;
                    repeat (400) begin
                        @(posedge ref_clk);
                        #1 n += driveState[2].level;
                    end
                    chk("clkHigh", 8'hC8, 8'(n));
                end
            end
        end
        $display("test done: source");
    endtask : t_source

    task automatic t_pullup();
        for (int o = 0; o < 10; o++) begin
            for (int p = 0; p < 16; p++) begin
                wr(8'(8'h07 + 8 * o), {4'h3, 4'(p)});
                settle();
                chkOut(o, {3'h3, 4'(p)});
            end
        end
        $display("test done: pullup");
    endtask : t_pullup

    task automatic t_clock();
        int n;
        n = 0;
        while (intClkOut === 1'b1 && n < 500) begin
            @(posedge ref_clk);
            #1 n++;
        end
        while (intClkOut !== 1'b1 && n < 500) begin
            @(posedge ref_clk);
            #1 n++;
        end
        for (int h = 1; h >= 0; h--) begin
            n = 0;
            while (intClkOut === h[0] && n < 500) begin
                @(posedge ref_clk);
                #1 n++;
            end
            chk("clkHalf", 8'hC8, 8'(n));
        end
        $display("test done: clock");
    endtask : t_clock

    initial begin
        failures = 0;
        samples_checked = 0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_regs();
        t_source();
        t_pullup();
        t_clock();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        tally_and_finish();
    end
endmodule : programmable_output_select_tb
`default_nettype wire
